//--- hw/asp_regs.svh
// Register offsets, field positions, reset values and divider counts of the serial port
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH

`define ASP_ADDR_W 8
`define ASP_OFS_CTRL 8'h00
`define ASP_OFS_DATA 8'h04
`define ASP_OFS_TCTL 8'h08
`define ASP_OFS_RELOAD 8'h0C
`define ASP_OFS_LOW 8'h10

`define ASP_CTRL_MODE 7
`define ASP_CTRL_ONE 6
`define ASP_CTRL_MCE 5
`define ASP_CTRL_REN 4
`define ASP_CTRL_TB8 3
`define ASP_CTRL_RB8 2
`define ASP_CTRL_TI 1
`define ASP_CTRL_RI 0
`define ASP_CTRL_RESET 8'h40

`define ASP_TCTL_RUN 0
`define ASP_TCTL_SRC_LO 1
`define ASP_TCTL_IEN 4

`define ASP_SRC_CORE 3'h0
`define ASP_SRC_DIV4 3'h1
`define ASP_SRC_DIV12 3'h2
`define ASP_SRC_DIV48 3'h3
`define ASP_SRC_OSC8 3'h4
`define ASP_SRC_PIN 3'h5

`define ASP_DIV4_LAST 2'h3
`define ASP_DIV12_LAST 4'hB
`define ASP_DIV48_LAST 6'h2F
`define ASP_DIV8_LAST 3'h7
`define ASP_TIMER_TOP 8'hFF

`define ASP_BITS_8BIT 4'hA
`define ASP_BITS_9BIT 4'hB
`define ASP_RX_LAST_8BIT 4'h8
`define ASP_RX_LAST_9BIT 4'h9

`define ASP_RESP_OKAY 2'h0
`define ASP_RESP_SLVERR 2'h2

`endif

//--- hw/asp_pkg.sv
// Types shared by the serial port modules
`include "asp_regs.svh"
package asp_pkg;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_WAIT = 2'b01,
		TX_SHIFT = 2'b10
	} asp_tx_e;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10
	} asp_rx_e;

	typedef struct packed {
		logic [1:0] c4;
		logic [3:0] c12;
		logic [5:0] c48;
		logic [2:0] c8;
		logic osc_q;
		logic pin_q;
	} asp_tick_s;

	typedef struct packed {
		logic [7:0] cnt;
		logic half;
	} asp_timer_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_held;
		logic [`ASP_ADDR_W-1:0] awaddr_q;
		logic w_held;
		logic [7:0] wdata_q;
		logic wstrb_q;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic mode;
		logic mce;
		logic ren;
		logic tb8;
		logic rb8;
		logic ti;
		logic ri;
		logic run;
		logic [2:0] src;
		logic ien;
		logic [7:0] reload;
		logic irq;
		asp_tx_e tx_state;
		logic [10:0] tx_frame;
		logic [3:0] tx_left;
		logic txd;
		asp_rx_e rx_state;
		logic [9:0] rx_shift;
		logic [3:0] rx_idx;
		logic rx_prev;
		logic [7:0] rx_buf;
	} asp_top_s;
endpackage

//--- hw/asp_tick_sel.sv
// Baud timer input selector: one-cycle count enables from six sources
`timescale 1ns/1ps
module asp_tick_sel import asp_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [2:0] src,
	input wire logic ext_osc,
	input wire logic ext_pin,
	output logic tick
);
	asp_tick_s s_ff;
	asp_tick_s nxt_s;

	// Free-running prescalers; they never stop, so a source change takes effect at once
	always_comb begin
		nxt_s = s_ff;
		nxt_s.c4 = (s_ff.c4 == `ASP_DIV4_LAST) ? 2'h0 : s_ff.c4 + 2'h1;
		nxt_s.c12 = (s_ff.c12 == `ASP_DIV12_LAST) ? 4'h0 : s_ff.c12 + 4'h1;
		nxt_s.c48 = (s_ff.c48 == `ASP_DIV48_LAST) ? 6'h00 : s_ff.c48 + 6'h01;
		nxt_s.osc_q = ext_osc;
		nxt_s.pin_q = ext_pin;
		if (ext_osc && !s_ff.osc_q) begin
			nxt_s.c8 = s_ff.c8 + 3'h1;
		end
		tick = 1'b0;
		// Six selectable timer sources
		case (src)
			`ASP_SRC_CORE: tick = 1'b1;
			`ASP_SRC_DIV4: tick = (s_ff.c4 == `ASP_DIV4_LAST);
			`ASP_SRC_DIV12: tick = (s_ff.c12 == `ASP_DIV12_LAST);
			`ASP_SRC_DIV48: tick = (s_ff.c48 == `ASP_DIV48_LAST);
			`ASP_SRC_OSC8: tick = ext_osc && !s_ff.osc_q && (s_ff.c8 == `ASP_DIV8_LAST);
			`ASP_SRC_PIN: tick = ext_pin && !s_ff.pin_q;
			default: tick = 1'b0;
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule // asp_tick_sel

//--- hw/asp_baud_timer.sv
// Eight-bit auto-reload counter with forced reload and divide-by-two of its overflows
`timescale 1ns/1ps
module asp_baud_timer import asp_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic tick,
	input wire logic run,
	input wire logic [7:0] reload,
	input wire logic force_reload,
	input wire logic load_en,
	input wire logic [7:0] load_val,
	output logic [7:0] count,
	output logic bit_tick
);
	asp_timer_s s_ff;
	asp_timer_s nxt_s;
	logic ovf;

	// Overflow every 256 minus reload input ticks, bit tick on every second one
	always_comb begin
		nxt_s = s_ff;
		ovf = tick && run && (s_ff.cnt == `ASP_TIMER_TOP);
		bit_tick = ovf && !s_ff.half;
		count = s_ff.cnt;
		if (force_reload) begin
			// Restarting the phase too puts the first bit tick half a bit later
			nxt_s.cnt = reload;
			nxt_s.half = 1'b0;
		end else if (load_en) begin
			nxt_s.cnt = load_val;
		end else if (tick && run) begin
			nxt_s.cnt = ovf ? reload : s_ff.cnt + 8'h01;
			if (ovf) begin
				nxt_s.half = !s_ff.half;
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule // asp_baud_timer

//--- hw/asp_top.sv
// Asynchronous serial port with auto-reload baud timer and AXI4-Lite registers
`timescale 1ns/1ps
module asp_top import asp_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register bus, write side
	input wire logic [`ASP_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Register bus, read side
	input wire logic [`ASP_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial line and timer sources
	input wire logic rxd,
	output logic txd,
	input wire logic ext_osc,
	input wire logic timer_external_input,
	output logic irq
);
	asp_top_s s_ff;
	asp_top_s nxt_s;
	// Timer outputs; the receive counter's value is never shown to software
	logic timer_tick;
	logic [7:0] low_count;
	logic tx_bit_tick;
	logic rx_bit_tick;
	logic start_seen;
	// Decoded write strobes
	logic wr_go;
	logic wr_ctrl;
	logic wr_data;
	logic wr_tctl;
	logic wr_reload;
	logic wr_low;
	logic ti_set;
	logic ri_set;
	logic [3:0] rx_last;

	// Shared input for both counters
	asp_tick_sel u_tick_sel (
		.clk(clk),
		.arst_n(arst_n),
		.src(s_ff.src),
		.ext_osc(ext_osc),
		.ext_pin(timer_external_input),
		.tick(timer_tick)
	);

	// Transmit counter; this is the timer low count software sees
	asp_baud_timer u_tx_timer (
		.clk(clk),
		.arst_n(arst_n),
		.tick(timer_tick),
		.run(s_ff.run),
		.reload(s_ff.reload),
		.force_reload(1'b0),
		.load_en(wr_low),
		.load_val(s_ff.wdata_q),
		.count(low_count),
		.bit_tick(tx_bit_tick)
	);

	// Private receive counter, no register loads or reads its count
	asp_baud_timer u_rx_timer (
		.clk(clk),
		.arst_n(arst_n),
		.tick(timer_tick),
		.run(s_ff.run),
		.reload(s_ff.reload),
		.force_reload(start_seen),
		.load_en(1'b0),
		.load_val(8'h00),
		.count(),
		.bit_tick(rx_bit_tick)
	);

	// Falling receive edge while idle and enabled
	assign start_seen = (s_ff.rx_state == RX_IDLE) && s_ff.ren && s_ff.rx_prev && !rxd;

	// Register map, one byte lane each:
	//   0x00 control: frame width, reads one, qualify, receive enable,
	//        ninth transmit bit, ninth receive bit, transmit done, receive done
	//   0x04 data buffer: write sends, read returns the receive latch
	//   0x08 timer control: run, three source bits, interrupt enable
	//   0x0C reload byte
	//   0x10 timer low count: write loads it, read shows it
	// Write strobes, only once address and data are both held and no response is pending
	always_comb begin
		wr_go = s_ff.aw_held && s_ff.w_held && !s_ff.bvalid;
		// No strobe unless the decode below picks one
		wr_ctrl = 1'b0;
		wr_data = 1'b0;
		wr_tctl = 1'b0;
		wr_reload = 1'b0;
		wr_low = 1'b0;
		// All registers live in byte lane 0; other lanes are ignored
		if (wr_go && s_ff.wstrb_q) begin
			if (s_ff.awaddr_q == `ASP_OFS_CTRL) begin
				wr_ctrl = 1'b1;
			end else if (s_ff.awaddr_q == `ASP_OFS_DATA) begin
				wr_data = 1'b1;
			end else if (s_ff.awaddr_q == `ASP_OFS_TCTL) begin
				wr_tctl = 1'b1;
			end else if (s_ff.awaddr_q == `ASP_OFS_RELOAD) begin
				wr_reload = 1'b1;
			end else if (s_ff.awaddr_q == `ASP_OFS_LOW) begin
				wr_low = 1'b1;
			end
		end
	end

	// Next-state logic
	always_comb begin
		nxt_s = s_ff;
		// Flag set requests from the shifters
		ti_set = 1'b0;
		ri_set = 1'b0;
		rx_last = s_ff.mode ? `ASP_RX_LAST_9BIT : `ASP_RX_LAST_8BIT;

		// Write address and data channels, taken in either order
		if (s_ff.awready && s_axi_awvalid) begin
			nxt_s.aw_held = 1'b1;
			nxt_s.awaddr_q = s_axi_awaddr;
		end
		// Only byte lane 0 is kept; the other lanes carry nothing
		if (s_ff.wready && s_axi_wvalid) begin
			nxt_s.w_held = 1'b1;
			nxt_s.wdata_q = s_axi_wdata[7:0];
			nxt_s.wstrb_q = s_axi_wstrb[0];
		end
		// Response leaves at its handshake
		if (s_ff.bvalid && s_axi_bready) begin
			nxt_s.bvalid = 1'b0;
		end
		// Execute once both beats are held; unmapped addresses answer with an error
		if (wr_go) begin
			nxt_s.aw_held = 1'b0;
			nxt_s.w_held = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = `ASP_RESP_SLVERR;
			if ((s_ff.awaddr_q == `ASP_OFS_CTRL) || (s_ff.awaddr_q == `ASP_OFS_DATA) ||
				(s_ff.awaddr_q == `ASP_OFS_TCTL) || (s_ff.awaddr_q == `ASP_OFS_RELOAD) ||
				(s_ff.awaddr_q == `ASP_OFS_LOW)) begin
				nxt_s.bresp = `ASP_RESP_OKAY;
			end
		end
		// A held beat blocks its channel until the write executes
		nxt_s.awready = !nxt_s.aw_held;
		nxt_s.wready = !nxt_s.w_held;

		// Read channel; the data buffer address shows only the receive latch
		if (s_ff.rvalid && s_axi_rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (s_ff.arready && s_axi_arvalid) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = `ASP_RESP_OKAY;
			nxt_s.rdata = 32'h0000_0000;
			if (s_axi_araddr == `ASP_OFS_CTRL) begin
				nxt_s.rdata[7:0] = {s_ff.mode, 1'b1, s_ff.mce, s_ff.ren,
					s_ff.tb8, s_ff.rb8, s_ff.ti, s_ff.ri};
			end else if (s_axi_araddr == `ASP_OFS_DATA) begin
				nxt_s.rdata[7:0] = s_ff.rx_buf;
			end else if (s_axi_araddr == `ASP_OFS_TCTL) begin
				nxt_s.rdata[4:0] = {s_ff.ien, s_ff.src, s_ff.run};
			end else if (s_axi_araddr == `ASP_OFS_RELOAD) begin
				nxt_s.rdata[7:0] = s_ff.reload;
			end else if (s_axi_araddr == `ASP_OFS_LOW) begin
				nxt_s.rdata[7:0] = low_count;
			end else begin
				nxt_s.rresp = `ASP_RESP_SLVERR;
			end
		end
		// One read at a time: no new address while data waits
		nxt_s.arready = !nxt_s.rvalid;

		// Configuration writes; flags take their written value, hardware sets come later
		if (wr_ctrl) begin
			nxt_s.mode = s_ff.wdata_q[`ASP_CTRL_MODE];
			nxt_s.mce = s_ff.wdata_q[`ASP_CTRL_MCE];
			nxt_s.ren = s_ff.wdata_q[`ASP_CTRL_REN];
			nxt_s.tb8 = s_ff.wdata_q[`ASP_CTRL_TB8];
			nxt_s.rb8 = s_ff.wdata_q[`ASP_CTRL_RB8];
			nxt_s.ti = s_ff.wdata_q[`ASP_CTRL_TI];
			nxt_s.ri = s_ff.wdata_q[`ASP_CTRL_RI];
		end
		// Timer control and reload byte
		if (wr_tctl) begin
			nxt_s.run = s_ff.wdata_q[`ASP_TCTL_RUN];
			nxt_s.src = s_ff.wdata_q[`ASP_TCTL_SRC_LO +: 3];
			nxt_s.ien = s_ff.wdata_q[`ASP_TCTL_IEN];
		end
		if (wr_reload) begin
			nxt_s.reload = s_ff.wdata_q;
		end

		// Transmitter: shifts on transmit bit ticks, line high when idle
		case (s_ff.tx_state)
			TX_WAIT: begin
				// A cut frame must not leave the line low while the next one waits
				nxt_s.txd = 1'b1;
				if (tx_bit_tick) begin
					nxt_s.tx_state = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				if (tx_bit_tick) begin
					nxt_s.txd = s_ff.tx_frame[0];
					nxt_s.tx_frame = {1'b1, s_ff.tx_frame[10:1]};
					nxt_s.tx_left = s_ff.tx_left - 4'h1;
					// Done flag rises as the stop bit goes out; the line then idles high
					if (s_ff.tx_left == 4'h1) begin
						ti_set = 1'b1;
						nxt_s.tx_state = TX_IDLE;
					end
				end
			end
			default: begin
				nxt_s.txd = 1'b1;
			end
		endcase
		// A write restarts the transmitter even mid-frame; the old byte is cut short
		if (wr_data) begin
			nxt_s.tx_state = TX_WAIT;
			if (s_ff.mode) begin
				nxt_s.tx_frame = {1'b1, s_ff.tb8, s_ff.wdata_q, 1'b0};
				nxt_s.tx_left = `ASP_BITS_9BIT;
			end else begin
				nxt_s.tx_frame = {2'b11, s_ff.wdata_q, 1'b0};
				nxt_s.tx_left = `ASP_BITS_8BIT;
			end
		end

		// Receiver: bit ticks from the private counter fall mid-bit after a start
		nxt_s.rx_prev = rxd;

		// Receive frame sequencing
		case (s_ff.rx_state)
			RX_IDLE: begin
				if (start_seen) begin
					nxt_s.rx_state = RX_START;
				end
			end
			RX_START: begin
				// A high level at the start-bit centre was a glitch, not a start
				if (rx_bit_tick) begin
					nxt_s.rx_state = rxd ? RX_IDLE : RX_DATA;
					nxt_s.rx_idx = 4'h0;
				end
			end
			RX_DATA: begin
				if (rx_bit_tick) begin
					nxt_s.rx_shift[s_ff.rx_idx] = rxd;
					nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
					if (s_ff.rx_idx == rx_last) begin
						nxt_s.rx_state = RX_IDLE;
						// Slot 8 holds the stop bit in 8-bit frames, the ninth bit in 9-bit ones
						if (!s_ff.ri && (!s_ff.mce || nxt_s.rx_shift[8])) begin
							nxt_s.rx_buf = nxt_s.rx_shift[7:0];
							nxt_s.rb8 = nxt_s.rx_shift[8];
							ri_set = 1'b1;
						end
					end
				end
			end
			default: begin
				nxt_s.rx_state = RX_IDLE;
			end
		endcase
		// Clearing receive enable abandons a frame in progress
		if (!s_ff.ren) begin
			nxt_s.rx_state = RX_IDLE;
		end

		// Hardware set wins over a software clear in the same cycle
		if (ti_set) begin
			nxt_s.ti = 1'b1;
		end
		if (ri_set) begin
			nxt_s.ri = 1'b1;
		end
		// Level request, registered in the same cycle as the flags
		nxt_s.irq = nxt_s.ien && (nxt_s.ti || nxt_s.ri);
	end

	// State register; bus readies come up one cycle after reset release
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= '{tx_state: TX_IDLE, rx_state: RX_IDLE, txd: 1'b1, rx_prev: 1'b1,
				default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from the state register
	assign s_axi_awready = s_ff.awready;
	assign s_axi_wready = s_ff.wready;
	assign s_axi_bvalid = s_ff.bvalid;
	assign s_axi_bresp = s_ff.bresp;
	assign s_axi_arready = s_ff.arready;
	assign s_axi_rvalid = s_ff.rvalid;
	assign s_axi_rdata = s_ff.rdata;
	assign s_axi_rresp = s_ff.rresp;
	assign txd = s_ff.txd;
	assign irq = s_ff.irq;
endmodule // asp_top

//--- test/asp_top_asserts.sv
// Port-level checks of the serial port register bus and transmit line
`timescale 1ns/1ps
`include "asp_regs.svh"
module asp_top_asserts (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic txd
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_wr_ans;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write response late");
	property p_b_code;
		s_axi_bvalid |-> s_axi_bresp inside {`ASP_RESP_OKAY, `ASP_RESP_SLVERR};
	endproperty
	a_b_code: assert property (p_b_code) else $error("bad write response code");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	property p_rd_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
	property p_r_err;
		s_axi_rvalid && s_axi_rresp == `ASP_RESP_SLVERR |-> s_axi_rdata == 32'h0;
	endproperty
	a_r_err: assert property (p_r_err) else $error("refused read leaks data");
	// Every bit lasts at least two clocks, two overflows, unless a data write lands on the bit tick that starts a low bit, which leaves a one-clock low
	property p_start_len;
		$fell(txd) |=> !txd;
	endproperty
	a_start_len: assert property (p_start_len) else $error("short low on txd");
endmodule // asp_top_asserts

bind asp_top asp_top_asserts chk (.clk(clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.txd(txd));

//--- test/asp_peer.sv
// Far-side serial node: sends frames on rxd and captures frames from txd
`timescale 1ns/1ps
module asp_peer #(parameter int BIT = 8) (
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	initial rxd = 1'b1;
	// Start bit, then bits LSB first; line returns high after the last one
	task automatic send(input logic [9:0] bits, input int n);
		@(posedge clk);
		rxd <= 1'b0;
		repeat (BIT) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			rxd <= bits[i];
			repeat (BIT) @(posedge clk);
		end
		rxd <= 1'b1;
	endtask
	// Bounded wait for a start, then sample bit centres
	task automatic recv(input int n, output logic [9:0] bits, output logic ok);
		int t;
		bits = '0;
		t = 0;
		while (txd !== 1'b0 && t < 4000) begin
			@(posedge clk);
			t++;
		end
		ok = (t < 4000);
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			repeat (BIT) @(posedge clk);
			bits[i] = txd;
		end
	endtask
endmodule // asp_peer

//--- test/asp_top_test.sv
// Self-checking bench of the serial port against a far-side serial peer and fixed expected values
`timescale 1ns/1ps
`include "asp_regs.svh"
module asp_top_test;
	logic clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic rvalid, rready, rxd, txd, ext_osc, ext_pin, irq, ok, st;
	logic [7:0] awaddr, araddr, d, c, v, exp_buf;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [9:0] bits;
	logic [7:0] ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	logic [7:0] rst_v [5] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
	int pre [4] = '{1, 4, 12, 48};
	int mismatches, total_checks, seed, k;

	asp_top uut (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd(rxd),
		.txd(txd), .ext_osc(ext_osc), .timer_external_input(ext_pin), .irq(irq));
	// Reload 0xFC on the core clock gives 2*(256-252) clocks per bit
	asp_peer #(.BIT(8)) peer (.clk(clk), .txd(txd), .rxd(rxd));

	// 50 MHz clock
	initial clk = 1'b0;
	always #10 clk = ~clk;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	// Bus waits are bounded; running out ends the run as a failure
	task automatic hang(input int n);
		if (n >= 50) begin
			check("bus answer", 32'h1, 32'h0);
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
		logic ad, wd;
		int n;
		ad = 1'b0;
		wd = 1'b0;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd) && n < 50) begin
			@(posedge clk);
			n++;
			if (awvalid && awready)
				ad = 1'b1;
			if (wvalid && wready)
				wd = 1'b1;
			if (ad)
				awvalid <= 1'b0;
			if (wd)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		hang(n);
		bready <= 1'b0;
		check("write response", 32'(er), 32'(bresp));
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [7:0] dat);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!(arvalid && arready) && n < 50) begin
			@(posedge clk);
			n++;
		end
		arvalid <= 1'b0;
		while (rvalid !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		hang(n);
		rready <= 1'b0;
		dat = rdata[7:0];
		check("read response", 32'(er), 32'(rresp));
	endtask
	// Rising edges on the oscillator or on the timer pin
	task automatic pulse(input logic osc, input int n);
		for (int i = 0; i < 2 * n; i++) begin
			@(posedge clk);
			if (osc)
				ext_osc <= ~ext_osc;
			else
				ext_pin <= ~ext_pin;
		end
	endtask
	task automatic irq_after(input logic [7:0] a, input logic [7:0] val, input logic e);
		wr(a, 32'(val), `ASP_RESP_OKAY);
		repeat (2) @(posedge clk);
		check("irq", 32'(e), 32'(irq));
	endtask

	// Main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, ext_osc, ext_pin} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		arst_n = 1'b0;
		seed = 32'hB9BB88D1;
		mismatches = 0;
		total_checks = 0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		for (k = 0; k < 5; k++) begin
			rd(ofs[k], `ASP_RESP_OKAY, v);
			check("reset value", 32'(rst_v[k]), 32'(v));
		end
		// A write with lane 0 disabled is answered but changes nothing
		wstrb <= 4'hE;
		wr(`ASP_OFS_RELOAD, 32'hAA, `ASP_RESP_OKAY);
		wstrb <= 4'hF;
		rd(`ASP_OFS_RELOAD, `ASP_RESP_OKAY, v);
		check("masked write", 32'h0, 32'(v));
		rd(8'h14, `ASP_RESP_SLVERR, v);
		check("unmapped read", 32'h0, 32'(v));
		wr(8'h20, 32'h0, `ASP_RESP_SLVERR);
		// Pin and oscillator sources; the pin run crosses an overflow
		wr(`ASP_OFS_RELOAD, 32'hF0, `ASP_RESP_OKAY);
		wr(`ASP_OFS_TCTL, 32'h0B, `ASP_RESP_OKAY);
		wr(`ASP_OFS_LOW, 32'hFE, `ASP_RESP_OKAY);
		pulse(1'b0, 3);
		rd(`ASP_OFS_LOW, `ASP_RESP_OKAY, v);
		check("pin count", 32'hF1, 32'(v));
		wr(`ASP_OFS_TCTL, 32'h09, `ASP_RESP_OKAY);
		wr(`ASP_OFS_LOW, 32'h20, `ASP_RESP_OKAY);
		pulse(1'b1, 16);
		rd(`ASP_OFS_LOW, `ASP_RESP_OKAY, v);
		check("osc count", 32'h22, 32'(v));
		// Prescaled core clock: a window of two whole prescaler periods holds two ticks
		for (k = 1; k < 4; k++) begin
			wr(`ASP_OFS_TCTL, 32'(2 * k + 1), `ASP_RESP_OKAY);
			wr(`ASP_OFS_LOW, 32'h10, `ASP_RESP_OKAY);
			repeat (pre[k] * 2 - 2) @(posedge clk);
			rd(`ASP_OFS_LOW, `ASP_RESP_OKAY, v);
			check("prescaled count", 32'h12, 32'(v));
		end
		wr(`ASP_OFS_RELOAD, 32'hFC, `ASP_RESP_OKAY);
		wr(`ASP_OFS_TCTL, 32'h11, `ASP_RESP_OKAY);
		wr(`ASP_OFS_CTRL, 32'h10, `ASP_RESP_OKAY);
		// Both directions at once in 8-bit frames
		d = $random(seed);
		exp_buf = $random(seed);
		fork
			wr(`ASP_OFS_DATA, 32'(d), `ASP_RESP_OKAY);
			peer.recv(9, bits, ok);
			peer.send({2'b11, exp_buf}, 9);
		join
		check("tx frame", {22'h0, 2'b11, d}, {22'h0, ok, bits[8:0]});
		if (ok !== 1'b1)
			stop_test();
		rd(`ASP_OFS_DATA, `ASP_RESP_OKAY, v);
		check("rx data", 32'(exp_buf), 32'(v));
		rd(`ASP_OFS_CTRL, `ASP_RESP_OKAY, v);
		check("ctrl flags", 32'h57, 32'(v));
		check("irq", 32'h1, 32'(irq));
		irq_after(`ASP_OFS_TCTL, 8'h01, 1'b0);
		irq_after(`ASP_OFS_TCTL, 8'h11, 1'b1);
		irq_after(`ASP_OFS_CTRL, 8'h98, 1'b0);
		// 9-bit transmit carries the ninth transmit bit
		d = $random(seed);
		fork
			wr(`ASP_OFS_DATA, 32'(d), `ASP_RESP_OKAY);
			peer.recv(10, bits, ok);
		join
		check("tx frame 9", {21'h0, 3'b111, d}, {21'h0, ok, bits});
		if (ok !== 1'b1)
			stop_test();
		rd(`ASP_OFS_CTRL, `ASP_RESP_OKAY, v);
		check("ctrl tx flag", 32'hDA, 32'(v));
		// Every mode, qualifier and ninth/stop value, at a random phase
		for (k = 0; k < 8; k++) begin
			c = {k[2], 1'b1, k[1], 5'h10};
			wr(`ASP_OFS_CTRL, 32'(c), `ASP_RESP_OKAY);
			d = $random(seed);
			repeat ($random(seed) & 7) @(posedge clk);
			peer.send({1'b1, k[0], d}, 9 + k[2]);
			st = !k[1] || k[0];
			if (st)
				exp_buf = d;
			if (k == 0)
				peer.send({2'b11, ~d}, 9);
			rd(`ASP_OFS_DATA, `ASP_RESP_OKAY, v);
			check("rx buffer", 32'(exp_buf), 32'(v));
			rd(`ASP_OFS_CTRL, `ASP_RESP_OKAY, v);
			check("rx flags", 32'({c[7:3], st & k[0], 1'b0, st}), 32'(v));
		end
		stop_test();
	end
endmodule // asp_top_test
